// >>> core/cmpms_pkg.sv
// Constants shared by the comparator mode and input select logic
package cmpms_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] CMPMS_ADDR_STATUS = 8'h9b;
  localparam logic [7:0] CMPMS_ADDR_MODE = 8'h9d;
  localparam logic [7:0] CMPMS_ADDR_INSEL = 8'h9f;
  localparam logic [7:0] CMPMS_SFR_PAGE = 8'h00;

  // ==========================================================
  // Field layout
  localparam int CMPMS_STAT_OUT_BIT = 6;
  localparam int CMPMS_STAT_RISE_BIT = 5;
  localparam int CMPMS_STAT_FALL_BIT = 4;
  localparam int CMPMS_MODE_RIE_BIT = 5;
  localparam int CMPMS_MODE_FIE_BIT = 4;
  localparam int CMPMS_MODE_RM_LSB = 0;
  localparam int CMPMS_INSEL_NEG_LSB = 4;
  localparam int CMPMS_INSEL_POS_LSB = 0;
  localparam logic [7:0] CMPMS_MODE_WMASK = 8'h33;
  localparam logic [7:0] CMPMS_INSEL_WMASK = 8'h77;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CMPMS_MODE_RESET = 8'h02;
  localparam logic [7:0] CMPMS_INSEL_RESET = 8'h00;

  // ==========================================================
  // Package options and multiplexer codes
  typedef enum logic [1:0] {
    CMPMS_PKG_64 = 2'h0,
    CMPMS_PKG_48 = 2'h1,
    CMPMS_PKG_32 = 2'h2,
    CMPMS_PKG_24 = 2'h3
  } cmpms_package_e;

  localparam logic [2:0] CMPMS_CODES_LARGE = 3'h4;
  localparam logic [2:0] CMPMS_CODES_48 = 3'h2;
  localparam logic [2:0] CMPMS_CODE_SMALL = 3'h3;

endpackage : cmpms_pkg

// >>> core/cmpms_input_mux.sv
// Decode of comparator input select codes into pin connections
`timescale 1ns/10ps
`default_nettype none

module cmpms_input_mux
  import cmpms_pkg::*;
(
  // Configuration
  input wire cmpms_package_e i_package,
  input wire logic [2:0] i_neg_code,
  input wire logic [2:0] i_pos_code,
  // Connections, at most one set per input over port 1 bits and port 2 bit 0
  output logic [7:0] o_neg_p1,
  output logic o_neg_p2_0,
  output logic [7:0] o_pos_p1
);

  // Port 1 bit 2*code+odd when the code is within the pin count
  function automatic logic [7:0] cmpms_pin_decode(
    input logic [2:0] code,
    input logic odd,
    input cmpms_package_e pkg
  );
    logic [7:0] one;
    logic [3:0] idx;
    one = 8'h01;
    idx = {code, odd};
    cmpms_pin_decode = 8'h00;
    case (pkg)
      CMPMS_PKG_64: begin
        if (code < CMPMS_CODES_LARGE) begin
          cmpms_pin_decode = one << idx[2:0];
        end
      end
      CMPMS_PKG_48: begin
        if (code < CMPMS_CODES_48) begin
          cmpms_pin_decode = one << idx[2:0];
        end
      end
      default: begin
        if (!odd && code == CMPMS_CODE_SMALL) begin
          cmpms_pin_decode = one << idx[2:0];
        end
      end
    endcase
  endfunction : cmpms_pin_decode

  logic small_pkg;

  assign small_pkg = (i_package == CMPMS_PKG_32) ||
                     (i_package == CMPMS_PKG_24);
  assign o_neg_p1 = cmpms_pin_decode(i_neg_code, 1'b1, i_package);
  assign o_pos_p1 = cmpms_pin_decode(i_pos_code, 1'b0, i_package);
  assign o_neg_p2_0 = small_pkg && (i_neg_code == CMPMS_CODE_SMALL);

endmodule : cmpms_input_mux

`default_nettype wire

// >>> core/cmpms_regs.sv
// Comparator mode, input select and edge flag registers
`timescale 1ns/10ps
`default_nettype none

module cmpms_regs
  import cmpms_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Special-function register port
  input wire logic [7:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_we,
  input wire logic i_sfr_re,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // Package bonding option
  input wire cmpms_package_e i_package,
  // Analog comparator core
  input wire logic i_cmp_raw,
  output logic [1:0] o_response_mode,
  output logic o_cmp_output_state,
  // Input multiplexer
  output logic [7:0] o_neg_p1,
  output logic o_neg_p2_0,
  output logic [7:0] o_pos_p1,
  // Interrupt side
  output logic o_rise_irq_enable,
  output logic o_fall_irq_enable,
  output logic o_rise_edge_flag,
  output logic o_fall_edge_flag,
  output logic o_irq
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] insel;
    logic sync1;
    logic sync2;
    logic prev;
    logic rise_flag;
    logic fall_flag;
    logic irq;
    logic [7:0] rdata;
    logic [7:0] neg_p1;
    logic neg_p2_0;
    logic [7:0] pos_p1;
  } cmpms_state_s;

  cmpms_state_s st;
  cmpms_state_s next_st;
  logic [7:0] next_insel;
  logic page_hit;
  logic wr_mode;
  logic wr_insel;
  logic wr_stat;
  logic rise_evt;
  logic fall_evt;
  logic [7:0] mux_neg_p1;
  logic mux_neg_p2_0;
  logic [7:0] mux_pos_p1;

  // ==========================================================
  // Address decode
  assign page_hit = (i_sfr_page == CMPMS_SFR_PAGE);
  assign wr_mode = i_sfr_we && page_hit && (i_sfr_addr == CMPMS_ADDR_MODE);
  assign wr_insel = i_sfr_we && page_hit &&
                    (i_sfr_addr == CMPMS_ADDR_INSEL);
  assign wr_stat = i_sfr_we && page_hit &&
                   (i_sfr_addr == CMPMS_ADDR_STATUS);
  assign next_insel = wr_insel ? (i_sfr_wdata & CMPMS_INSEL_WMASK)
                               : st.insel;

  // ==========================================================
  // Input multiplexer decode, registered below
  cmpms_input_mux u_mux (
    .i_package(i_package),
    .i_neg_code(next_insel[CMPMS_INSEL_NEG_LSB +: 3]),
    .i_pos_code(next_insel[CMPMS_INSEL_POS_LSB +: 3]),
    .o_neg_p1(mux_neg_p1),
    .o_neg_p2_0(mux_neg_p2_0),
    .o_pos_p1(mux_pos_p1)
  );

  // Edges seen on the synchronised comparator output
  assign rise_evt = st.sync2 && !st.prev;
  assign fall_evt = !st.sync2 && st.prev;

  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    next_st.sync1 = i_cmp_raw;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    if (wr_mode) begin
      next_st.mode = i_sfr_wdata & CMPMS_MODE_WMASK;
    end
    next_st.insel = next_insel;
    next_st.neg_p1 = mux_neg_p1;
    next_st.neg_p2_0 = mux_neg_p2_0;
    next_st.pos_p1 = mux_pos_p1;
    // Hardware set wins over a software clear in the same cycle
    next_st.rise_flag = (wr_stat ? i_sfr_wdata[CMPMS_STAT_RISE_BIT]
                                 : st.rise_flag) || rise_evt;
    next_st.fall_flag = (wr_stat ? i_sfr_wdata[CMPMS_STAT_FALL_BIT]
                                 : st.fall_flag) || fall_evt;
    next_st.irq =
      (next_st.rise_flag && next_st.mode[CMPMS_MODE_RIE_BIT]) ||
      (next_st.fall_flag && next_st.mode[CMPMS_MODE_FIE_BIT]);
    if (i_sfr_re) begin
      next_st.rdata = 8'h00;
      if (page_hit) begin
        case (i_sfr_addr)
          CMPMS_ADDR_MODE: next_st.rdata = st.mode;
          CMPMS_ADDR_INSEL: next_st.rdata = st.insel;
          CMPMS_ADDR_STATUS: begin
            next_st.rdata[CMPMS_STAT_OUT_BIT] = st.sync2;
            next_st.rdata[CMPMS_STAT_RISE_BIT] = st.rise_flag;
            next_st.rdata[CMPMS_STAT_FALL_BIT] = st.fall_flag;
          end
          default: next_st.rdata = 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // State register, frozen while the clock enable is low
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.mode <= CMPMS_MODE_RESET;
      st.insel <= CMPMS_INSEL_RESET;
      st.neg_p1 <= 8'h00;
      st.pos_p1 <= 8'h00;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign o_sfr_rdata = st.rdata;
  assign o_response_mode = st.mode[CMPMS_MODE_RM_LSB +: 2];
  assign o_cmp_output_state = st.sync2;
  assign o_neg_p1 = st.neg_p1;
  assign o_neg_p2_0 = st.neg_p2_0;
  assign o_pos_p1 = st.pos_p1;
  assign o_rise_irq_enable = st.mode[CMPMS_MODE_RIE_BIT];
  assign o_fall_irq_enable = st.mode[CMPMS_MODE_FIE_BIT];
  assign o_rise_edge_flag = st.rise_flag;
  assign o_fall_edge_flag = st.fall_flag;
  assign o_irq = st.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic rd_mode;
  logic rd_insel;
  logic [7:0] exp_neg;
  logic [7:0] one_hot;
  logic [3:0] neg_idx;

  assign rd_mode = i_sfr_re && page_hit && (i_sfr_addr == CMPMS_ADDR_MODE);
  assign rd_insel = i_sfr_re && page_hit &&
                    (i_sfr_addr == CMPMS_ADDR_INSEL);
  assign one_hot = 8'h01;
  assign neg_idx = {st.insel[CMPMS_INSEL_NEG_LSB +: 3], 1'b1};
  assign exp_neg = (st.insel[CMPMS_INSEL_NEG_LSB +: 3] < CMPMS_CODES_LARGE)
                   ? (one_hot << neg_idx[2:0]) : 8'h00;

  property p_rise_gate;
    o_rise_edge_flag && !o_rise_irq_enable &&
    !(o_fall_edge_flag && o_fall_irq_enable) |-> !o_irq;
  endproperty
  a_rise_gate: assert property (p_rise_gate)
    else $error("irq raised by masked rising flag");

  property p_fall_gate;
    o_fall_edge_flag && o_fall_irq_enable |-> o_irq;
  endproperty
  a_fall_gate: assert property (p_fall_gate)
    else $error("enabled falling flag gave no irq");

  property p_mode_write;
    wr_mode && i_clk_en |=> o_response_mode == $past(i_sfr_wdata[1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("response mode not taken from write");

  property p_mode_rsvd;
    rd_mode && i_clk_en |=> (o_sfr_rdata & ~CMPMS_MODE_WMASK) == 8'h00;
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd)
    else $error("mode reserved bits read nonzero");

  property p_insel_rsvd;
    rd_insel && i_clk_en |=> (o_sfr_rdata & ~CMPMS_INSEL_WMASK) == 8'h00;
  endproperty
  a_insel_rsvd: assert property (p_insel_rsvd)
    else $error("select reserved bits read nonzero");

  // Mux flops read zero until the first edge after reset, so skip that edge
  property p_neg_large;
    $past(i_reset_n) && $past(i_clk_en) && i_package == CMPMS_PKG_64 &&
    $stable(i_package) |-> o_neg_p1 == exp_neg && !o_neg_p2_0;
  endproperty
  a_neg_large: assert property (p_neg_large)
    else $error("negative mux wrong on large package");

  property p_pos_48;
    $past(i_clk_en) && i_package == CMPMS_PKG_48 && $stable(i_package)
      |-> o_pos_p1[7:4] == 4'h0 && o_neg_p1[7:4] == 4'h0;
  endproperty
  a_pos_48: assert property (p_pos_48)
    else $error("upper pins connected on 48-pin package");

  property p_small;
    $past(i_clk_en) && i_package == CMPMS_PKG_32 && $stable(i_package) &&
    st.insel[CMPMS_INSEL_NEG_LSB +: 3] == CMPMS_CODE_SMALL
      |-> o_neg_p2_0 && o_neg_p1 == 8'h00;
  endproperty
  a_small: assert property (p_small)
    else $error("port 2 bit 0 not selected on small package");

  // Software may clear the flag as soon as it has been seen set
  property p_rise_set;
    i_clk_en && rise_evt |=>
      o_rise_edge_flag ##1 (o_rise_edge_flag || $past(wr_stat));
  endproperty
  a_rise_set: assert property (p_rise_set)
    else $error("rising flag not set and held");

  property p_sticky;
    o_fall_edge_flag && !wr_stat |=> o_fall_edge_flag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("falling flag dropped without a write");

  property p_out_state;
    (i_cmp_raw && i_clk_en) [*3] |=> o_cmp_output_state;
  endproperty
  a_out_state: assert property (p_out_state)
    else $error("output state does not follow comparator");

  c_irq: cover property (o_irq);
  c_clear: cover property (o_rise_edge_flag && wr_stat && i_clk_en
                           ##1 !o_rise_edge_flag);
  c_small: cover property (o_neg_p2_0 && o_pos_p1[6]);
  c_set_wins: cover property (wr_stat && rise_evt && i_clk_en);

endmodule : cmpms_regs

`default_nettype wire

// >>> dv/cmpms_cmp_model.sv
// Behavioural model of the analog comparator core behind the input mux
`timescale 1ns/10ps
`default_nettype none

module cmpms_cmp_model (
  // Voltages of pins set as analog inputs and skipped by the crossbar
  input wire logic [7:0] i_pos_level,
  input wire logic [7:0] i_neg_level,
  // Raw comparator output
  output logic o_raw
);
  // ==========================================================
  // Compare
  assign o_raw = (i_pos_level > i_neg_level);
endmodule : cmpms_cmp_model

`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the comparator mode and input select registers
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import cmpms_pkg::*;

  // ==========================================================
  // Signals
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_sfr_we = 1'b0;
  logic i_sfr_re = 1'b0;
  logic [7:0] i_sfr_page = 8'h00;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  cmpms_package_e i_package = CMPMS_PKG_64;
  logic [7:0] pos_lvl = 8'h00;
  logic [7:0] neg_lvl = 8'h64;
  logic clk_en = 1'b1;
  logic cmp_raw;
  logic [7:0] rdata;
  logic [1:0] rmode;
  logic [7:0] np1;
  logic [7:0] pp1;
  logic cout, rie, fie, rflag, fflag, irq, np2;
  int n_fail = 0;
  int checks_done = 0;

  always #50 i_clk = ~i_clk;

  // ==========================================================
  // Design and comparator core
  cmpms_regs i_cmpms_regs (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_clk_en(clk_en),
    .i_sfr_page(i_sfr_page), .i_sfr_addr(i_sfr_addr),
    .i_sfr_we(i_sfr_we), .i_sfr_re(i_sfr_re),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(rdata),
    .i_package(i_package), .i_cmp_raw(cmp_raw),
    .o_response_mode(rmode), .o_cmp_output_state(cout),
    .o_neg_p1(np1), .o_neg_p2_0(np2), .o_pos_p1(pp1),
    .o_rise_irq_enable(rie), .o_fall_irq_enable(fie),
    .o_rise_edge_flag(rflag), .o_fall_edge_flag(fflag), .o_irq(irq)
  );

  cmpms_cmp_model i_cmpms_cmp_model (
    .i_pos_level(pos_lvl), .i_neg_level(neg_lvl), .o_raw(cmp_raw)
  );

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] pg, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge i_clk);
    i_sfr_page <= pg;
    i_sfr_addr <= a;
    i_sfr_wdata <= d;
    i_sfr_we <= 1'b1;
    @(posedge i_clk);
    i_sfr_we <= 1'b0;
    i_sfr_page <= 8'h00;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_sfr_addr <= a;
    i_sfr_re <= 1'b1;
    @(posedge i_clk);
    i_sfr_re <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rd

  task automatic settle;
    repeat (5) @(posedge i_clk);
    #1;
  endtask : settle

  function automatic logic [15:0] mux_exp(int pk, int c, int ng);
    logic [15:0] r;
    r = '0;
    if (c < 4 && (pk == 0 || (pk == 1 && c < 2))) begin
      r[2 * c + ng] = 1'b1;
    end else if (pk >= 2 && c == 3) begin
      r = (ng == 1) ? 16'h0100 : 16'h0040;
    end
    return r;
  endfunction : mux_exp

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // ==========================================================
  // Tests
  initial begin
    repeat (20) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(CMPMS_ADDR_MODE, 8'h02);
    rd(CMPMS_ADDR_INSEL, 8'h00);
    chk({rie, fie, rmode}, 16'h0002);
    $display("test reset done");
    wr(8'h00, CMPMS_ADDR_MODE, 8'hff);
    rd(CMPMS_ADDR_MODE, 8'h33);
    wr(8'h00, CMPMS_ADDR_INSEL, 8'hff);
    rd(CMPMS_ADDR_INSEL, 8'h77);
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, CMPMS_ADDR_MODE, 8'(m));
      chk(rmode, 16'(m));
      rd(CMPMS_ADDR_MODE, 8'(m));
    end
    // A write while the clock enable is low must not land
    @(posedge i_clk);
    clk_en <= 1'b0;
    wr(8'h00, CMPMS_ADDR_MODE, 8'h21);
    chk({rie, rmode}, 16'h0003);
    clk_en <= 1'b1;
    wr(8'h01, CMPMS_ADDR_MODE, 8'h31);
    wr(8'h00, 8'h9e, 8'h31);
    rd(CMPMS_ADDR_MODE, 8'h03);
    rd(8'h9e, 8'h00);
    $display("test fields done");
    for (int pk = 0; pk < 4; pk++) begin
      for (int c = 0; c < 8; c++) begin
        i_package <= cmpms_package_e'(pk[1:0]);
        wr(8'h00, CMPMS_ADDR_INSEL, {1'b0, c[2:0], 1'b0, c[2:0]});
        chk({7'h00, np2, np1}, mux_exp(pk, c, 1));
        chk(pp1, mux_exp(pk, c, 0));
      end
    end
    $display("test mux done");
    wr(8'h00, CMPMS_ADDR_MODE, 8'h20);
    @(posedge i_clk);
    pos_lvl <= 8'hc8;
    settle();
    chk({cout, rflag, fflag, irq}, 16'h000d);
    rd(CMPMS_ADDR_STATUS, 8'h60);
    wr(8'h00, CMPMS_ADDR_STATUS, 8'h00);
    chk({rflag, irq}, 16'h0000);
    @(posedge i_clk);
    pos_lvl <= 8'h00;
    settle();
    chk({cout, rflag, fflag, irq}, 16'h0002);
    wr(8'h00, CMPMS_ADDR_MODE, 8'h10);
    chk(irq, 16'h0001);
    wr(8'h00, CMPMS_ADDR_MODE, 8'h00);
    wr(8'h00, CMPMS_ADDR_STATUS, 8'h00);
    @(posedge i_clk);
    pos_lvl <= 8'hc8;
    settle();
    chk({rflag, irq}, 16'h0002);
    $display("test edges done");
    // Reset in mid-run with the comparator low and a flag still set
    @(posedge i_clk);
    pos_lvl <= 8'h00;
    settle();
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(CMPMS_ADDR_MODE, 8'h02);
    chk({rie, fie, rmode, rflag, fflag, irq}, 16'h0010);
    $display("test mid reset done");
    close_out();
  end

  // ==========================================================
  // Watchdog
  initial begin
    repeat (3000) @(posedge i_clk);
    n_fail++;
    close_out();
  end
endmodule : testbench

`default_nettype wire
